// ---- include/timer16_defines.svh ----
// Overview of operation
// - Clock select 1 advances the counter on every system clock cycle.
// - Clock selects 2..5 count on prescaler taps of 8, 64, 256, 1024.
// - Prescaler runs freely, so a first prescaled count takes 1 to N cycles.
// - Software can reset the prescaler to align counting with the program.
// - With no clock source selected the counter gets no count pulses.
// - Count pin is sampled each cycle and fed to an edge detector.
// - Synchronizer is a clock-high transparent latch then rising-edge flops.
// - One count pulse per rising edge on code 7, per falling edge on 6.
// - Counter updates 2.5 to 3.5 cycles after a count pin edge.
// - Pin edges drive the counter directly, never through the prescaler.
// - 16-bit counter counts up or down by one, or clears to zero.
// - Bottom is 0x00, maximum is 0xFF; top is maximum or compare A.
// - Double-buffered compares match the counter and set their flags.
// - Compare A as top is not a wave source and stays double buffered.
// - Capture latches the count on a chosen edge of pin or comparator.
// - Four sources: overflow, compare A, compare B, capture, flags and masks.
// - Both 8-bit control registers are plainly readable and writable.
// - Count high byte goes through a temporary byte, moved on low access.
// - A software write to the counter beats clear or count that cycle.
// - Clock select 0 stops the timer; the count stays accessible.
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

`define ADDR_W 4
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h1
`define OFS_COUNT_L 4'h2
`define OFS_COUNT_H 4'h3
`define OFS_CMPA_L 4'h4
`define OFS_CMPA_H 4'h5
`define OFS_CMPB_L 4'h6
`define OFS_CMPB_H 4'h7
`define OFS_CAP_L 4'h8
`define OFS_CAP_H 4'h9
`define OFS_FLAG 4'hA
`define OFS_MASK 4'hB
`define OFS_PRESC 4'hC

`define CA_TOP_CMPA 0
`define CA_DUAL_SLOPE 1
`define CA_CAP_COMPARATOR 2
`define CB_CS_HI 2
`define CB_CS_LO 0
`define CB_CAP_RISE 6
`define CB_NOISE_CANCEL 7
`define PRESC_RST_BIT 0

`define FLAG_OVF 0
`define FLAG_MATCH_A 1
`define FLAG_MATCH_B 2
`define FLAG_CAPT 3

`define CS_STOP 3'h0
`define CS_DIRECT 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_PIN_FALL 3'h6
`define CS_PIN_RISE 3'h7

`define PRESC_W 10
`define TAP8_MASK 10'h007
`define TAP64_MASK 10'h03F
`define TAP256_MASK 10'h0FF
`define TAP1024_MASK 10'h3FF

`define BOTTOM_VALUE 16'h0000
`define MAX_VALUE 16'h00FF
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_FLAGS 4'h0
`define NOISE_SAMPLES 4

`endif

// ---- include/timer16_pkg.sv ----
package timer16_pkg;
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } edge_evt_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;
endpackage : timer16_pkg

// ---- rtl/timer16_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer16_pin_sync (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic pin_in,
  output var timer16_pkg::edge_evt_t edge_out
);
  logic latch_q;
  logic samp_ff;
  logic sync_ff;
  logic prev_ff;

  // Open in the high phase so the sample settles before the rising edge
  always_latch begin
    if (clk_in) begin
      latch_q <= pin_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      samp_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      samp_ff <= latch_q;
      sync_ff <= samp_ff;
      prev_ff <= sync_ff;
    end
  end

  // Extra stage puts the count update 2.5 to 3.5 cycles after the pin edge
  assign edge_out.level = sync_ff;
  assign edge_out.rise = sync_ff & ~prev_ff;
  assign edge_out.fall = ~sync_ff & prev_ff;
endmodule : timer16_pin_sync
`default_nettype wire

// ---- rtl/timer16_clock_select_counter.sv ----
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"
module timer16_clock_select_counter #(
  parameter int NOISE_SAMPLES = `NOISE_SAMPLES
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic EXT_COUNT_PIN_IN,
  input wire logic CAPTURE_PIN_IN,
  input wire logic COMPARATOR_IN,
  output var logic [7:0] RDATA_OUT,
  output var logic [3:0] IRQ_OUT,
  output var logic MATCH_A_OUT,
  output var logic MATCH_B_OUT,
  output var logic CAPTURE_TRIG_OUT,
  output var logic [15:0] TOP_OUT
);
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic tap_due(input logic [`PRESC_W-1:0] cnt,
                                   input logic [`PRESC_W-1:0] mask);
    tap_due = ((cnt & mask) == mask);
  endfunction : tap_due

  timer16_pkg::bus_req_t req;
  assign req = {ADDR_IN, WDATA_IN, WR_IN, RD_IN};

  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [7:0] temp_ff;
  logic [15:0] count_ff;
  logic [15:0] cmpa_buf_ff;
  logic [15:0] cmpa_act_ff;
  logic [15:0] cmpb_buf_ff;
  logic [15:0] cmpb_act_ff;
  logic [15:0] cap_ff;
  logic [3:0] flag_ff;
  logic [3:0] mask_ff;
  logic [`PRESC_W-1:0] presc_ff;
  timer16_pkg::count_dir_t dir_ff;
  logic [NOISE_SAMPLES-1:0] nc_hist_ff;
  logic nc_level_ff;
  logic nc_prev_ff;

  logic [7:0] nxt_temp;
  logic [15:0] nxt_count;
  timer16_pkg::count_dir_t nxt_dir;
  logic [3:0] nxt_flag;
  logic [7:0] nxt_rdata;

  // Bus decode
  wire wr_ctrl_a = req.wr & hit(req.addr, `OFS_CTRL_A);
  wire wr_ctrl_b = req.wr & hit(req.addr, `OFS_CTRL_B);
  wire wr_count_l = req.wr & hit(req.addr, `OFS_COUNT_L);
  wire wr_count_h = req.wr & hit(req.addr, `OFS_COUNT_H);
  wire wr_cmpa_l = req.wr & hit(req.addr, `OFS_CMPA_L);
  wire wr_cmpa_h = req.wr & hit(req.addr, `OFS_CMPA_H);
  wire wr_cmpb_l = req.wr & hit(req.addr, `OFS_CMPB_L);
  wire wr_cmpb_h = req.wr & hit(req.addr, `OFS_CMPB_H);
  wire wr_flag = req.wr & hit(req.addr, `OFS_FLAG);
  wire wr_mask = req.wr & hit(req.addr, `OFS_MASK);
  wire wr_presc = req.wr & hit(req.addr, `OFS_PRESC);
  wire rd_count_l = req.rd & hit(req.addr, `OFS_COUNT_L);
  wire rd_cap_l = req.rd & hit(req.addr, `OFS_CAP_L);
  wire wr_any_high = wr_count_h | wr_cmpa_h | wr_cmpb_h;

  wire [2:0] clock_select_field = ctrl_b_ff[`CB_CS_HI:`CB_CS_LO];
  wire top_from_cmpa = ctrl_a_ff[`CA_TOP_CMPA];
  wire dual_slope = ctrl_a_ff[`CA_DUAL_SLOPE];

  // Prescaler: free running, only SRST_IN or the software reset moves its phase
  wire presc_rst = wr_presc & req.wdata[`PRESC_RST_BIT];

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || presc_rst) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  wire tap8 = tap_due(presc_ff, `TAP8_MASK);
  wire tap64 = tap_due(presc_ff, `TAP64_MASK);
  wire tap256 = tap_due(presc_ff, `TAP256_MASK);
  wire tap1024 = tap_due(presc_ff, `TAP1024_MASK);

  // Count pin synchronizer and edge detector
  timer16_pkg::edge_evt_t pin_evt;
  timer16_pin_sync u_count_sync (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .pin_in(EXT_COUNT_PIN_IN),
    .edge_out(pin_evt)
  );

  // Clock select: pin edges bypass the prescaler entirely
  logic count_clock;
  always_comb begin
    case (clock_select_field)
      `CS_STOP: count_clock = 1'b0;
      `CS_DIRECT: count_clock = 1'b1;
      `CS_DIV8: count_clock = tap8;
      `CS_DIV64: count_clock = tap64;
      `CS_DIV256: count_clock = tap256;
      `CS_DIV1024: count_clock = tap1024;
      `CS_PIN_FALL: count_clock = pin_evt.fall;
      `CS_PIN_RISE: count_clock = pin_evt.rise;
      default: count_clock = 1'b0;
    endcase
  end

  // Top and bottom detection
  wire [15:0] top_value = top_from_cmpa ? cmpa_act_ff : `MAX_VALUE;
  wire at_top = (count_ff == top_value);
  wire at_bottom = (count_ff == `BOTTOM_VALUE);

  // Counter unit
  logic ovf_evt;
  always_comb begin
    nxt_count = count_ff;
    nxt_dir = dir_ff;
    ovf_evt = 1'b0;
    if (wr_count_l) begin
      nxt_count = {temp_ff, req.wdata};
    end else if (count_clock) begin
      if (!dual_slope) begin
        nxt_dir = timer16_pkg::DIR_UP;
        if (at_top) begin
          nxt_count = `BOTTOM_VALUE;
          ovf_evt = 1'b1;
        end else begin
          nxt_count = count_ff + 16'h0001;
        end
      end else if (dir_ff == timer16_pkg::DIR_UP) begin
        if (at_top) begin
          nxt_dir = timer16_pkg::DIR_DOWN;
          nxt_count = count_ff - 16'h0001;
        end else begin
          nxt_count = count_ff + 16'h0001;
        end
      end else begin
        if (at_bottom) begin
          nxt_dir = timer16_pkg::DIR_UP;
          nxt_count = count_ff + 16'h0001;
          ovf_evt = 1'b1;
        end else begin
          nxt_count = count_ff - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      count_ff <= `RST_WORD;
      dir_ff <= timer16_pkg::DIR_UP;
    end else begin
      count_ff <= nxt_count;
      dir_ff <= nxt_dir;
    end
  end

  // Shared high-byte temporary
  always_comb begin
    nxt_temp = temp_ff;
    if (wr_any_high) begin
      nxt_temp = req.wdata;
    end else if (rd_count_l) begin
      nxt_temp = count_ff[15:8];
    end else if (rd_cap_l) begin
      nxt_temp = cap_ff[15:8];
    end
  end

  // Control, mask and temporary registers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ctrl_a_ff <= `RST_BYTE;
      ctrl_b_ff <= `RST_BYTE;
      mask_ff <= `RST_FLAGS;
      temp_ff <= `RST_BYTE;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_ff <= req.wdata;
      end
      if (wr_ctrl_b) begin
        ctrl_b_ff <= req.wdata;
      end
      if (wr_mask) begin
        mask_ff <= req.wdata[3:0];
      end
      temp_ff <= nxt_temp;
    end
  end

  // Compare buffers: active copies load at top, or at once while stopped,
  // so a changing top never skips past the running count
  wire cmp_load = (clock_select_field == `CS_STOP) | (count_clock & at_top);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cmpa_buf_ff <= `RST_WORD;
      cmpb_buf_ff <= `RST_WORD;
      cmpa_act_ff <= `RST_WORD;
      cmpb_act_ff <= `RST_WORD;
    end else begin
      if (wr_cmpa_l) begin
        cmpa_buf_ff <= {temp_ff, req.wdata};
      end
      if (wr_cmpb_l) begin
        cmpb_buf_ff <= {temp_ff, req.wdata};
      end
      if (cmp_load) begin
        cmpa_act_ff <= cmpa_buf_ff;
        cmpb_act_ff <= cmpb_buf_ff;
      end
    end
  end

  // Matches are taken on count pulses so a parked counter flags only once
  wire match_a = count_clock & (count_ff == cmpa_act_ff);
  wire match_b = count_clock & (count_ff == cmpb_act_ff);

  // Capture source: pin or comparator, through the same sampling path
  wire cap_src = ctrl_a_ff[`CA_CAP_COMPARATOR] ? COMPARATOR_IN
                                                : CAPTURE_PIN_IN;
  timer16_pkg::edge_evt_t cap_evt_raw;
  timer16_pin_sync u_capture_sync (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .pin_in(cap_src),
    .edge_out(cap_evt_raw)
  );

  // Noise canceler: output follows only after all samples agree
  wire nc_all_high = &nc_hist_ff;
  wire nc_all_low = ~|nc_hist_ff;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      nc_hist_ff <= '0;
      nc_level_ff <= 1'b0;
      nc_prev_ff <= 1'b0;
    end else begin
      nc_hist_ff <= {nc_hist_ff[NOISE_SAMPLES-2:0], cap_evt_raw.level};
      if (nc_all_high) begin
        nc_level_ff <= 1'b1;
      end else if (nc_all_low) begin
        nc_level_ff <= 1'b0;
      end
      nc_prev_ff <= nc_level_ff;
    end
  end

  wire noise_on = ctrl_b_ff[`CB_NOISE_CANCEL];
  wire cap_rise_sel = ctrl_b_ff[`CB_CAP_RISE];
  wire cap_rise = noise_on ? (nc_level_ff & ~nc_prev_ff) : cap_evt_raw.rise;
  wire cap_fall = noise_on ? (~nc_level_ff & nc_prev_ff) : cap_evt_raw.fall;
  wire cap_trig = cap_rise_sel ? cap_rise : cap_fall;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cap_ff <= `RST_WORD;
    end else if (cap_trig) begin
      cap_ff <= count_ff;
    end
  end

  // Flags: write one to clear, a same-cycle event wins over the clear
  wire [3:0] flag_set = {cap_trig, match_b, match_a, ovf_evt};
  wire [3:0] flag_clr = wr_flag ? req.wdata[3:0] : 4'h0;

  always_comb begin
    nxt_flag = (flag_ff & ~flag_clr) | flag_set;
  end

  // Read mux; count high reads the temporary byte
  always_comb begin
    case (req.addr)
      `OFS_CTRL_A: nxt_rdata = ctrl_a_ff;
      `OFS_CTRL_B: nxt_rdata = ctrl_b_ff;
      `OFS_COUNT_L: nxt_rdata = count_ff[7:0];
      `OFS_COUNT_H: nxt_rdata = temp_ff;
      `OFS_CMPA_L: nxt_rdata = cmpa_buf_ff[7:0];
      `OFS_CMPA_H: nxt_rdata = cmpa_buf_ff[15:8];
      `OFS_CMPB_L: nxt_rdata = cmpb_buf_ff[7:0];
      `OFS_CMPB_H: nxt_rdata = cmpb_buf_ff[15:8];
      `OFS_CAP_L: nxt_rdata = cap_ff[7:0];
      `OFS_CAP_H: nxt_rdata = temp_ff;
      `OFS_FLAG: nxt_rdata = {4'h0, flag_ff};
      `OFS_MASK: nxt_rdata = {4'h0, mask_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      flag_ff <= `RST_FLAGS;
      RDATA_OUT <= 8'h00;
      IRQ_OUT <= 4'h0;
      MATCH_A_OUT <= 1'b0;
      MATCH_B_OUT <= 1'b0;
      CAPTURE_TRIG_OUT <= 1'b0;
      TOP_OUT <= `MAX_VALUE;
    end else begin
      flag_ff <= nxt_flag;
      RDATA_OUT <= req.rd ? nxt_rdata : 8'h00;
      IRQ_OUT <= nxt_flag & mask_ff;
      MATCH_A_OUT <= match_a;
      MATCH_B_OUT <= match_b;
      CAPTURE_TRIG_OUT <= cap_trig;
      TOP_OUT <= top_value;
    end
  end
endmodule : timer16_clock_select_counter
`default_nettype wire

// ---- testbench/timer16_props.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"
module timer16_props #(
  parameter int NOISE_SAMPLES = `NOISE_SAMPLES
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic EXT_COUNT_PIN_IN,
  input wire logic CAPTURE_PIN_IN,
  input wire logic COMPARATOR_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [3:0] IRQ_OUT,
  input wire logic MATCH_A_OUT,
  input wire logic MATCH_B_OUT,
  input wire logic CAPTURE_TRIG_OUT,
  input wire logic [15:0] TOP_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence rd_unmapped_s;
    RD_IN && (ADDR_IN >= `OFS_PRESC);
  endsequence
  sequence data_zero_s;
    ##1 RDATA_OUT == 8'h00;
  endsequence
  rdata_idle_a: assert property (
    !RD_IN |=> RDATA_OUT == 8'h00) else $error("read data not idle");
  unmapped_zero_a: assert property (
    rd_unmapped_s |-> data_zero_s) else $error("unmapped read not zero");
  reset_outputs_a: assert property (
    $fell(SRST_IN) |-> TOP_OUT == `MAX_VALUE && IRQ_OUT == 4'h0)
    else $error("outputs wrong after reset");
  top_fixed_a: assert property (
    WR_IN && ADDR_IN == `OFS_CTRL_A && !WDATA_IN[`CA_TOP_CMPA]
    |-> ##[1:3] TOP_OUT == `MAX_VALUE) else $error("top not fixed");
  mask_off_a: assert property (
    WR_IN && ADDR_IN == `OFS_MASK && WDATA_IN == 8'h00
    |-> ##[1:2] IRQ_OUT == 4'h0) else $error("masked request seen");
  match_a_pulse_a: assert property (
    MATCH_A_OUT |=> !MATCH_A_OUT) else $error("match a too long");
  match_b_pulse_a: assert property (
    $rose(MATCH_B_OUT) |=> !MATCH_B_OUT) else $error("match b too long");
  capture_pulse_a: assert property (
    CAPTURE_TRIG_OUT |=> !CAPTURE_TRIG_OUT) else $error("capture too long");
  cover property (MATCH_A_OUT);
endmodule : timer16_props
`default_nettype wire

// ---- testbench/ext_clock_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_clock_src (
  output logic pin_out
);
  // Pin idles low between bursts, so enabling the count clock is safe
  initial pin_out = 1'b0;
  // Offset keeps pin edges away from the system clock edges
  task automatic pulses(input int n, input int half_ns);
    #7;
    repeat (n) begin
      pin_out = 1'b1;
      #half_ns;
      pin_out = 1'b0;
      #half_ns;
    end
  endtask : pulses
endmodule : ext_clock_src
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic cap_pin = 1'b0;
  logic comp = 1'b0;
  wire logic pin;
  logic [7:0] rdata;
  logic [3:0] irq;
  logic match_a;
  logic match_b;
  logic cap_trig;
  logic [15:0] top;
  int n_errors = 0;
  int comparisons = 0;
  int n_ma = 0;
  int n_mb = 0;
  int n_cap = 0;
  int s0;
  int s1;
  logic [7:0] d0;
  logic [7:0] d1;
  int sp [6] = '{4, 4, 8, 64, 256, 1024};
  logic [7:0] ex [6] = '{8'h00, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01};
  always #10 clk = ~clk;
  // Pulse counters for the one-cycle event outputs
  always @(posedge clk) begin
    n_ma <= n_ma + int'(match_a);
    n_mb <= n_mb + int'(match_b);
    n_cap <= n_cap + int'(cap_trig);
  end
  timer16_clock_select_counter timer16_clock_select_counter_i (
    .CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_en), .RD_IN(rd_en), .EXT_COUNT_PIN_IN(pin),
    .CAPTURE_PIN_IN(cap_pin), .COMPARATOR_IN(comp), .RDATA_OUT(rdata),
    .IRQ_OUT(irq), .MATCH_A_OUT(match_a), .MATCH_B_OUT(match_b),
    .CAPTURE_TRIG_OUT(cap_trig), .TOP_OUT(top));
  ext_clock_src ext_clock_src_i (.pin_out(pin));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rd_chk
  // High byte first: the low write commits both halves together
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask : wr16
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    idle(20);
    srst <= 1'b0;
    check(top, `MAX_VALUE);
    rd_chk(`OFS_CTRL_B, 8'h00);
    rd_chk(`OFS_COUNT_L, 8'h00);
    rd_chk(4'hD, 8'h00);
    rd_chk(`OFS_PRESC, 8'h00);
    wr16(`OFS_COUNT_L, 16'h1234);
    rd_chk(`OFS_COUNT_L, 8'h34);
    rd_chk(`OFS_COUNT_H, 8'h12);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr16(`OFS_COUNT_L, 16'h0000);
      wr(`OFS_CTRL_B, i[7:0]);
      rd(`OFS_COUNT_L, d0);
      idle(sp[i] - 2);
      rd(`OFS_COUNT_L, d1);
      check({8'h00, d1 - d0}, {8'h00, ex[i]});
      wr(`OFS_CTRL_B, `RST_BYTE);
      rd(`OFS_COUNT_L, d0);
      rd(`OFS_COUNT_L, d1);
      check({8'h00, d1}, {8'h00, d0});
    end
    $display("test clock rates done");
    wr16(`OFS_COUNT_L, 16'h0000);
    // Restart first: the first tap then falls 8 cycles after the restart
    wr(`OFS_PRESC, 8'h01);
    wr(`OFS_CTRL_B, {5'h00, `CS_DIV8});
    idle(4);
    rd_chk(`OFS_COUNT_L, 8'h00);
    rd_chk(`OFS_COUNT_L, 8'h01);
    wr(`OFS_CTRL_B, `RST_BYTE);
    $display("test prescaler reset done");
    for (int c = 7; c >= 6; c--) begin
      wr16(`OFS_COUNT_L, 16'h0000);
      wr(`OFS_CTRL_B, c[7:0]);
      ext_clock_src_i.pulses(5, 60);
      idle(5);
      wr(`OFS_CTRL_B, `RST_BYTE);
      rd_chk(`OFS_COUNT_L, 8'h05);
      rd_chk(`OFS_COUNT_H, 8'h00);
    end
    $display("test pin clock done");
    wr16(`OFS_CMPA_L, 16'h0003);
    wr16(`OFS_CMPB_L, 16'h0006);
    wr16(`OFS_COUNT_L, 16'h0000);
    wr(`OFS_MASK, 8'h06);
    wr(`OFS_FLAG, 8'h0F);
    s0 = n_ma;
    s1 = n_mb;
    wr(`OFS_CTRL_B, {5'h00, `CS_DIRECT});
    idle(10);
    wr(`OFS_CTRL_B, `RST_BYTE);
    rd(`OFS_FLAG, d0);
    check({8'h00, d0 & 8'h07}, 16'h0006);
    check({12'h000, irq}, 16'h0006);
    check(16'(n_ma - s0), 16'h0001);
    check(16'(n_mb - s1), 16'h0001);
    wr(`OFS_FLAG, 8'h06);
    idle(2);
    rd(`OFS_FLAG, d0);
    check({8'h00, d0 & 8'h06}, 16'h0000);
    check({12'h000, irq}, 16'h0000);
    wr(`OFS_MASK, 8'h00);
    $display("test compare done");
    wr(`OFS_CTRL_A, 8'h01);
    rd_chk(`OFS_CTRL_A, 8'h01);
    check(top, 16'h0003);
    wr16(`OFS_CMPA_L, 16'h0009);
    idle(3);
    check(top, 16'h0009);
    wr(`OFS_CTRL_A, 8'h00);
    idle(3);
    check(top, `MAX_VALUE);
    $display("test top done");
    wr16(`OFS_CMPA_L, 16'h0003);
    wr16(`OFS_COUNT_L, 16'h0000);
    wr(`OFS_CTRL_A, 8'h01);
    wr(`OFS_FLAG, 8'h0F);
    wr(`OFS_CTRL_B, {5'h00, `CS_DIRECT});
    rd_chk(`OFS_COUNT_L, 8'h01);
    rd_chk(`OFS_COUNT_L, 8'h03);
    wr(`OFS_CTRL_B, `RST_BYTE);
    rd_chk(`OFS_COUNT_L, 8'h02);
    rd(`OFS_FLAG, d0);
    check({8'h00, d0 & 8'h01}, 16'h0001);
    // Dual slope turns at top: single slope would have wrapped to 0
    wr(`OFS_CTRL_A, 8'h03);
    wr16(`OFS_COUNT_L, 16'h0000);
    wr(`OFS_CTRL_B, {5'h00, `CS_DIRECT});
    idle(2);
    wr(`OFS_CTRL_B, `RST_BYTE);
    rd_chk(`OFS_COUNT_L, 8'h02);
    $display("test overflow done");
    wr16(`OFS_COUNT_L, 16'h0142);
    wr(`OFS_CTRL_B, 8'h40);
    rd_chk(`OFS_CTRL_B, 8'h40);
    wr(`OFS_FLAG, 8'h0F);
    s0 = n_cap;
    @(posedge clk);
    cap_pin <= 1'b1;
    idle(10);
    rd_chk(`OFS_CAP_L, 8'h42);
    rd_chk(`OFS_CAP_H, 8'h01);
    rd(`OFS_FLAG, d0);
    check({8'h00, d0 & 8'h08}, 16'h0008);
    check(16'(n_cap - s0), 16'h0001);
    @(posedge clk);
    cap_pin <= 1'b0;
    // Comparator source through the noise canceler, rising edge
    wr(`OFS_CTRL_A, 8'h04);
    wr(`OFS_CTRL_B, 8'hC0);
    wr16(`OFS_COUNT_L, 16'h0155);
    @(posedge clk);
    comp <= 1'b1;
    idle(12);
    rd_chk(`OFS_CAP_L, 8'h55);
    check(16'(n_cap - s0), 16'h0002);
    $display("test capture done");
    @(posedge clk);
    srst <= 1'b1;
    idle(3);
    srst <= 1'b0;
    rd_chk(`OFS_CTRL_B, 8'h00);
    rd_chk(`OFS_COUNT_L, 8'h00);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : testbench
bind timer16_clock_select_counter timer16_props #(
  .NOISE_SAMPLES(NOISE_SAMPLES)) timer16_props_i (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .EXT_COUNT_PIN_IN(EXT_COUNT_PIN_IN), .CAPTURE_PIN_IN(CAPTURE_PIN_IN),
  .COMPARATOR_IN(COMPARATOR_IN), .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT),
  .MATCH_A_OUT(MATCH_A_OUT), .MATCH_B_OUT(MATCH_B_OUT),
  .CAPTURE_TRIG_OUT(CAPTURE_TRIG_OUT), .TOP_OUT(TOP_OUT));
`default_nettype wire
